// ---- hdl/tpc_timer.sv ----
// Operation
// - three instances: four, two, two channels
// - channel: capture, compare or edge PWM
// - one bit sets center PWM per instance
// - own 16-bit counter, prescaler, modulo limit
// - prescaler divides 1 to 128 by powers
// - source: bus, fixed clock or pin
// - fixed clock is osc/2 only locked-external
// - capture on rising, falling or both edges
// - compare match sets, clears or toggles pin
// - PWM polarity high-true or low-true
// - count up, or up/down in center PWM
// - modulus bounds wrap or reversal point
// - interrupt per channel plus overflow
// - counter write clears counter and prescaler
// - debug freezes counter, reads show live value
// - debug write clears counter read latch
// - debug channel reads return real contents
// - debug channel control write clears latch
// - capture mode ignores channel value writes
// - compare value loads at next count, at once with clock source off
// - PWM value loads at modulus minus one
// - center PWM value equal modulus: full duty
`include "tpc_cfg.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module tpc_channel (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire tpc_pkg::tpc_ictl_t ictl,
  input wire tpc_pkg::tpc_time_t tb,
  input wire tpc_pkg::tpc_chbus_t cb,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic irq,
  output logic [7:0] rd_sc,
  output logic [7:0] rd_hi,
  output logic [7:0] rd_lo
);
  logic chf;
  logic chie;
  logic [1:0] ms;
  logic [1:0] els;
  logic [15:0] val;
  logic [15:0] wbuf;
  logic [15:0] rlat;
  logic [1:0] wseen;
  logic pend;
  logic rvld;
  logic pin_q;
  logic oc_out;

  wire is_pwm = ictl.center_aligned_pwm_mode | ms[1];
  wire is_cap = ~is_pwm & (ms == tpc_pkg::TPC_MS_CAP);
  wire is_oc = ~is_pwm & (ms == tpc_pkg::TPC_MS_OC);
  wire wr_v = (cb.wr_vh | cb.wr_vl) & ~is_cap;
  wire both = wr_v & ((wseen | {cb.wr_vh, cb.wr_vl}) == 2'b11);
  wire oc_ld = ictl.clk_on ? tb.tick : 1'b1;
  wire load_now = pend & ~is_cap & (is_pwm ? tb.pwm_ld : oc_ld);
  wire rise = pin_in & ~pin_q;
  wire fall = ~pin_in & pin_q;
  wire cap_ev = is_cap & ((els[0] & rise) | (els[1] & fall));
  wire match = tb.step & (tb.cnt == val);
  wire active = (tb.cnt < val) | (ictl.center_aligned_pwm_mode & (val == tb.top));
  wire chf_clr = cb.wr_sc & ~cb.wdata[`TPC_CSC_CHF];
  wire next_chf = cap_ev | (match & ~is_cap) | (chf & ~chf_clr);
  wire use_lat = rvld & ~ictl.background_debug_state;

  // compare action on match
  always_comb begin
    oc_out = pin_out;
    if (is_oc && match) begin
      case (els)
        2'b01: oc_out = ~pin_out;
        2'b10: oc_out = 1'b0;
        2'b11: oc_out = 1'b1;
        default: oc_out = pin_out;
      endcase
    end
  end

  assign irq = chf & chie;
  assign rd_sc = {chf, chie, ms, els, 2'b00};
  assign rd_hi = use_lat ? rlat[15:8] : val[15:8];
  assign rd_lo = use_lat ? rlat[7:0] : val[7:0];

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      {chf, chie, ms, els} <= 6'(`TPC_RST_BYTE >> 2);
      pin_q <= 1'b0;
    end else if (ce) begin
      chf <= next_chf;
      pin_q <= pin_in;
      if (cb.wr_sc) begin
        chie <= cb.wdata[`TPC_CSC_CHIE];
        ms <= cb.wdata[`TPC_CSC_MS_LSB +: 2];
        els <= cb.wdata[`TPC_CSC_ELS_LSB +: 2];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wbuf <= `TPC_RST_WORD;
      wseen <= 2'b00;
      pend <= 1'b0;
    end else if (ce) begin
      if (cb.wr_vh && wr_v) wbuf[15:8] <= cb.wdata;
      if (cb.wr_vl && wr_v) wbuf[7:0] <= cb.wdata;
      if (both || cb.wr_sc) wseen <= 2'b00;
      else if (wr_v) wseen <= wseen | {cb.wr_vh, cb.wr_vl};
      pend <= both | (pend & ~load_now);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      val <= `TPC_RST_WORD;
    end else if (ce) begin
      if (cap_ev) val <= tb.cnt;
      else if (load_now) val <= wbuf;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rvld <= 1'b0;
      rlat <= `TPC_RST_WORD;
    end else if (ce) begin
      if (ictl.background_debug_state && cb.wr_sc) rvld <= 1'b0;
      else if (cb.rd_v && !ictl.background_debug_state) begin
        rvld <= ~rvld;
        if (!rvld) rlat <= val;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else if (ce) begin
      pin_out <= is_pwm ? (active ^ els[0]) : oc_out;
      pin_oe <= ~is_cap & (els != 2'b00);
    end
  end

  a_cap_no_write: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (ce && is_cap && (cb.wr_vh || cb.wr_vl)) |=> (wbuf == $past(wbuf)))
    else $error("channel value buffer changed in capture mode");

  a_half_write: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (ce && wr_v && !both && !pend && !cap_ev) |=> (val == $past(val)) && !pend)
    else $error("single byte write changed channel value");

  a_cap_edge: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (ce && cap_ev) |=> (val == $past(tb.cnt)) && chf)
    else $error("capture did not store counter");

  a_oc_toggle: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (ce && is_oc && match && els == 2'b01) |=> (pin_out != $past(pin_out)))
    else $error("compare toggle missing");

  a_full_duty: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (ce && ictl.center_aligned_pwm_mode && val == tb.top && els == 2'b10) |=> pin_out)
    else $error("center pwm full duty not held");

  a_pwm_load: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (ce && pend && is_pwm && tb.pwm_ld && !cap_ev) |=> (val == $past(wbuf)))
    else $error("pwm value not loaded at period edge");

endmodule // tpc_channel

////////////////////////////////////////////////////////////////////////////////
module tpc_instance #(
  parameter int NCH = `TPC_CH_INSTN
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire logic background_debug_state,
  input wire logic fix_tick,
  input wire logic ext_rise,
  input wire tpc_pkg::tpc_bus_t bus,
  input wire logic [NCH-1:0] cap_in,
  output logic [NCH-1:0] pwm_out,
  output logic [NCH-1:0] pwm_oe,
  output logic [NCH-1:0] irq_ch,
  output logic irq_ovf,
  output logic [7:0] rd_byte
);
  if (NCH < 1 || NCH > `TPC_CH_MAX) begin : g_bad_nch
    $error("tpc_instance: channel count out of range");
  end

  function automatic logic is_ch_reg(input logic [4:0] off, input int c, input int k);
    is_ch_reg = (off == 5'(`TPC_OFF_CH0 + `TPC_CH_STRIDE * c + k));
  endfunction

  function automatic logic [6:0] ps_mask(input logic [2:0] ps_f);
    ps_mask = 7'((8'h01 << ps_f) - 8'h01);
  endfunction

  logic tof;
  logic toie;
  logic center_aligned_pwm_mode;
  logic [1:0] clks;
  logic [2:0] ps;
  logic [6:0] pre;
  logic [15:0] cnt;
  logic [15:0] modv;
  logic [15:0] clat;
  logic crvld;
  logic step;
  tpc_pkg::tpc_dir_t dir;
  tpc_pkg::tpc_dir_t next_dir;
  logic [15:0] next_cnt;
  logic wrap;
  logic src_tick;
  logic [7:0] ch_sc [NCH];
  logic [7:0] ch_hi [NCH];
  logic [7:0] ch_lo [NCH];

  wire wr_sc = bus.wr & (bus.off == `TPC_OFF_SC);
  wire wr_cnt = bus.wr & ((bus.off == `TPC_OFF_CNTH) | (bus.off == `TPC_OFF_CNTL));
  wire rd_cnt = bus.rd & ((bus.off == `TPC_OFF_CNTH) | (bus.off == `TPC_OFF_CNTL));
  wire [15:0] top_v = (modv == `TPC_RST_WORD) ? `TPC_CNT_FREE : modv;
  wire run = src_tick & ~background_debug_state;
  wire tick = run & ((pre & ps_mask(ps)) == ps_mask(ps)) & ~wr_cnt;
  wire pwm_ld = tick & (cnt == top_v - `TPC_CNT_ONE) & (dir == tpc_pkg::TPC_UP);
  wire [15:0] cnt_rd = (crvld && !background_debug_state) ? clat : cnt;
  wire tof_clr = wr_sc & ~bus.wdata[`TPC_SC_TOF];

  always_comb begin
    case (tpc_pkg::tpc_clksrc_t'(clks))
      tpc_pkg::TPC_CLK_BUS: src_tick = 1'b1;
      tpc_pkg::TPC_CLK_FIX: src_tick = fix_tick;
      tpc_pkg::TPC_CLK_EXT: src_tick = ext_rise;
      default: src_tick = 1'b0;
    endcase
  end

  // up counter, or up/down triangle in center mode
  always_comb begin
    next_cnt = cnt + `TPC_CNT_ONE;
    next_dir = dir;
    wrap = 1'b0;
    case (dir)
      tpc_pkg::TPC_UP: begin
        if (cnt >= top_v) begin
          wrap = 1'b1;
          next_cnt = center_aligned_pwm_mode ? cnt - `TPC_CNT_ONE : `TPC_RST_WORD;
          next_dir = center_aligned_pwm_mode ? tpc_pkg::TPC_DOWN : tpc_pkg::TPC_UP;
        end
      end
      tpc_pkg::TPC_DOWN: begin
        next_cnt = (cnt == `TPC_RST_WORD) ? `TPC_CNT_ONE : cnt - `TPC_CNT_ONE;
        if (cnt == `TPC_RST_WORD) next_dir = tpc_pkg::TPC_UP;
      end
      default: next_dir = tpc_pkg::TPC_UP;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      {tof, toie, center_aligned_pwm_mode, clks, ps} <= `TPC_RST_BYTE;
    end else if (ce) begin
      tof <= (tick & wrap) | (tof & ~tof_clr);
      if (wr_sc) {toie, center_aligned_pwm_mode, clks, ps} <= bus.wdata[`TPC_SC_TOIE:`TPC_SC_PS_LSB];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pre <= 7'h00;
      cnt <= `TPC_RST_WORD;
      dir <= tpc_pkg::TPC_UP;
      step <= 1'b0;
    end else if (ce) begin
      step <= tick;
      if (wr_cnt) begin
        pre <= 7'h00;
        cnt <= `TPC_RST_WORD;
        dir <= tpc_pkg::TPC_UP;
      end else begin
        if (run) pre <= pre + 7'h01;
        if (tick) cnt <= next_cnt;
        if (tick) dir <= center_aligned_pwm_mode ? next_dir : tpc_pkg::TPC_UP;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      modv <= `TPC_RST_WORD;
      crvld <= 1'b0;
      clat <= `TPC_RST_WORD;
    end else if (ce) begin
      if (bus.wr && bus.off == `TPC_OFF_MODH) modv[15:8] <= bus.wdata;
      if (bus.wr && bus.off == `TPC_OFF_MODL) modv[7:0] <= bus.wdata;
      if (wr_cnt || (background_debug_state && wr_sc)) crvld <= 1'b0;
      else if (rd_cnt && !background_debug_state) begin
        crvld <= ~crvld;
        if (!crvld) clat <= cnt;
      end
    end
  end

  assign irq_ovf = tof & toie;

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    tpc_pkg::tpc_chbus_t cb;
    assign cb.wr_sc = bus.wr & is_ch_reg(bus.off, c, 0);
    assign cb.wr_vh = bus.wr & is_ch_reg(bus.off, c, 1);
    assign cb.wr_vl = bus.wr & is_ch_reg(bus.off, c, 2);
    assign cb.rd_v = bus.rd & (is_ch_reg(bus.off, c, 1) | is_ch_reg(bus.off, c, 2));
    assign cb.wdata = bus.wdata;
    tpc_channel u_ch (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .ce(ce),
      .ictl({center_aligned_pwm_mode, clks != 2'b00, background_debug_state}),
      .tb({cnt, top_v, tick, step, pwm_ld}),
      .cb(cb),
      .pin_in(cap_in[c]),
      .pin_out(pwm_out[c]),
      .pin_oe(pwm_oe[c]),
      .irq(irq_ch[c]),
      .rd_sc(ch_sc[c]),
      .rd_hi(ch_hi[c]),
      .rd_lo(ch_lo[c])
    );
  end

  always_comb begin
    rd_byte = `TPC_RST_BYTE;
    case (bus.off)
      `TPC_OFF_SC: rd_byte = {tof, toie, center_aligned_pwm_mode, clks, ps};
      `TPC_OFF_CNTH: rd_byte = cnt_rd[15:8];
      `TPC_OFF_CNTL: rd_byte = cnt_rd[7:0];
      `TPC_OFF_MODH: rd_byte = modv[15:8];
      `TPC_OFF_MODL: rd_byte = modv[7:0];
      default: begin
        for (int c = 0; c < NCH; c++) begin
          if (is_ch_reg(bus.off, c, 0)) rd_byte = ch_sc[c];
          if (is_ch_reg(bus.off, c, 1)) rd_byte = ch_hi[c];
          if (is_ch_reg(bus.off, c, 2)) rd_byte = ch_lo[c];
        end
      end
    endcase
  end

  a_cnt_clear: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (ce && wr_cnt) |=> (cnt == `TPC_RST_WORD) && (pre == 7'h00))
    else $error("counter write did not clear counter and prescaler");

  a_bdm_freeze: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (background_debug_state && !wr_cnt) [*2] |-> (cnt == $past(cnt)))
    else $error("counter moved in debug");

  a_up_wrap: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (ce && tick && !center_aligned_pwm_mode && dir == tpc_pkg::TPC_UP && cnt >= top_v)
      |=> (cnt == `TPC_RST_WORD) && tof)
    else $error("counter did not wrap at modulus");

  a_up_count: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (ce && tick && dir == tpc_pkg::TPC_UP && cnt < top_v) |=> (cnt == $past(cnt) + 16'h0001))
    else $error("counter did not step up");

  a_dbg_read: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (bus.rd && background_debug_state && bus.off == `TPC_OFF_CNTH) |-> (rd_byte == cnt[15:8]))
    else $error("debug counter read not live");

  a_dbg_latch_clr: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (ce && background_debug_state && (wr_sc || wr_cnt)) |=> !crvld)
    else $error("debug write left read latch armed");

  a_psc_tick: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (tick && ps == 3'h7 && $stable(ps) && $past(ce)) |-> (pre == 7'h7f) && !$past(tick))
    else $error("divide by 128 tick misplaced");

endmodule // tpc_instance

////////////////////////////////////////////////////////////////////////////////
module tpc_timer #(
  parameter int CH_INST0 = `TPC_CH_INST0,
  parameter int CH_INSTN = `TPC_CH_INSTN,
  parameter int NCH_ALL = CH_INST0 + (`TPC_NUM_INST - 1) * CH_INSTN
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire logic bdm_active,
  input wire logic freq_locked_external_mode,
  input wire logic osc_ref_tick,
  input wire logic ext_timer_clock_pin,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [NCH_ALL-1:0] cap_in,
  output logic [NCH_ALL-1:0] pwm_out,
  output logic [NCH_ALL-1:0] pwm_oe,
  output logic [NCH_ALL-1:0] irq_ch,
  output logic [`TPC_NUM_INST-1:0] irq_ovf
);
  if (CH_INST0 < 1 || CH_INST0 > `TPC_CH_MAX || CH_INSTN < 1 || CH_INSTN > `TPC_CH_MAX)
  begin : g_bad_cfg
    $error("tpc_timer: channel counts out of range");
  end

  function automatic int inst_nch(input int i);
    inst_nch = (i == 0) ? CH_INST0 : CH_INSTN;
  endfunction

  function automatic int inst_base(input int i);
    inst_base = (i == 0) ? 0 : CH_INST0 + (i - 1) * CH_INSTN;
  endfunction

  logic osc_half;
  logic ext_q;
  logic [7:0] rd_sel;
  logic [7:0] inst_rd [`TPC_NUM_INST];

  wire fix_tick = freq_locked_external_mode ? (osc_ref_tick & osc_half) : 1'b1;
  wire ext_rise = ext_timer_clock_pin & ~ext_q;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      osc_half <= 1'b0;
      ext_q <= 1'b0;
      reg_rdata <= `TPC_RST_BYTE;
    end else if (ce) begin
      if (osc_ref_tick) osc_half <= ~osc_half;
      ext_q <= ext_timer_clock_pin;
      reg_rdata <= reg_rd ? rd_sel : `TPC_RST_BYTE;
    end
  end

  for (genvar i = 0; i < `TPC_NUM_INST; i++) begin : g_inst
    localparam int NCH = inst_nch(i);
    localparam int BASE = inst_base(i);
    tpc_pkg::tpc_bus_t ib;
    wire hit = (reg_addr[6:5] == 2'(i)) & ce;
    assign ib.off = reg_addr[4:0];
    assign ib.wdata = reg_wdata;
    assign ib.wr = reg_wr & hit;
    assign ib.rd = reg_rd & hit;
    tpc_instance #(.NCH(NCH)) u_inst (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .ce(ce),
      .background_debug_state(bdm_active),
      .fix_tick(fix_tick),
      .ext_rise(ext_rise),
      .bus(ib),
      .cap_in(cap_in[BASE +: NCH]),
      .pwm_out(pwm_out[BASE +: NCH]),
      .pwm_oe(pwm_oe[BASE +: NCH]),
      .irq_ch(irq_ch[BASE +: NCH]),
      .irq_ovf(irq_ovf[i]),
      .rd_byte(inst_rd[i])
    );
  end

  always_comb begin
    rd_sel = `TPC_RST_BYTE;
    for (int i = 0; i < `TPC_NUM_INST; i++) begin
      if (reg_addr[6:5] == 2'(i)) rd_sel = inst_rd[i];
    end
  end

  a_rd_only_after: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (ce && !reg_rd) |=> (reg_rdata == `TPC_RST_BYTE))
    else $error("read data outside read answer cycle");

endmodule // tpc_timer

`default_nettype wire

// ---- hdl/tpc_cfg.svh ----
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH

`define TPC_NUM_INST 3
`define TPC_CH_MAX 4
`define TPC_CH_INST0 4
`define TPC_CH_INSTN 2

`define TPC_OFF_SC 5'h00
`define TPC_OFF_CNTH 5'h01
`define TPC_OFF_CNTL 5'h02
`define TPC_OFF_MODH 5'h03
`define TPC_OFF_MODL 5'h04
`define TPC_OFF_CH0 5'h05
`define TPC_CH_STRIDE 5'h03

`define TPC_SC_TOF 7
`define TPC_SC_TOIE 6
`define TPC_SC_CENTER_ALIGNED_PWM_MODE 5
`define TPC_SC_CLKS_LSB 3
`define TPC_SC_PS_LSB 0

`define TPC_CSC_CHF 7
`define TPC_CSC_CHIE 6
`define TPC_CSC_MS_LSB 4
`define TPC_CSC_ELS_LSB 2

`define TPC_RST_BYTE 8'h00
`define TPC_RST_WORD 16'h0000
`define TPC_CNT_FREE 16'hffff
`define TPC_CNT_ONE 16'h0001

`endif

// ---- hdl/tpc_pkg.sv ----
`default_nettype none

package tpc_pkg;

  typedef enum logic [1:0] {
    TPC_CLK_OFF = 2'b00,
    TPC_CLK_BUS = 2'b01,
    TPC_CLK_FIX = 2'b10,
    TPC_CLK_EXT = 2'b11
  } tpc_clksrc_t;

  typedef enum logic [1:0] {
    TPC_MS_CAP = 2'b00,
    TPC_MS_OC = 2'b01,
    TPC_MS_PWM = 2'b10,
    TPC_MS_PWM_ALT = 2'b11
  } tpc_chmode_t;

  typedef enum logic {
    TPC_UP = 1'b0,
    TPC_DOWN = 1'b1
  } tpc_dir_t;

  typedef struct packed {
    logic [4:0] off;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tpc_bus_t;

  typedef struct packed {
    logic wr_sc;
    logic wr_vh;
    logic wr_vl;
    logic rd_v;
    logic [7:0] wdata;
  } tpc_chbus_t;

  typedef struct packed {
    logic center_aligned_pwm_mode;
    logic clk_on;
    logic background_debug_state;
  } tpc_ictl_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] top;
    logic tick;
    logic step;
    logic pwm_ld;
  } tpc_time_t;

endpackage

`default_nettype wire

// ---- sim/tpc_pins_model.sv ----
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module tpc_pins_model (
  input wire logic clk_sys,
  input wire logic ext_en,
  output logic ext_clk,
  output logic osc_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph = 2'h0;
  always_ff @(posedge clk_sys) begin
    ph <= ph + 2'h1;
  end
  // pin clock runs at a quarter of the bus rate, held low while ext_en is off
  assign ext_clk = ext_en & ph[1];
  // one reference pulse every four bus cycles
  assign osc_tick = (ph == 2'h3);
endmodule // tpc_pins_model

`default_nettype wire

// ---- sim/tb_timer_pwm_capture_compare.sv ----
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module tb_timer_pwm_capture_compare;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b0;
  logic background_debug_state = 1'b0;
  logic fle = 1'b0;
  logic ext_en = 1'b0;
  logic ext_clk;
  logic osc_tick;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] cap_in = 8'h00;
  logic [7:0] pwm_out;
  logic [7:0] pwm_oe;
  logic [7:0] irq_ch;
  logic [2:0] irq_ovf;
  int n_fail = 0;
  int cmp_count = 0;
  logic [15:0] w;
  logic [15:0] v;
  logic [7:0] h;
  logic [7:0] h2;
  int c;
  logic [7:0] t_sc [6] = '{8'h08, 8'h0b, 8'h10, 8'h10, 8'h18, 8'h0f};
  logic t_fle [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  int t_len [6] = '{32'h40, 32'h40, 32'h40, 32'h40, 32'h40, 32'h500};
  int t_div [6] = '{32'h1, 32'h8, 32'h1, 32'h8, 32'h4, 32'h80};

  always #12.5 clk_sys = ~clk_sys;

  tpc_pins_model u_tpc_pins_model (
    .clk_sys(clk_sys),
    .ext_en(ext_en),
    .ext_clk(ext_clk),
    .osc_tick(osc_tick)
  );

  tpc_timer u_tpc_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .bdm_active(background_debug_state),
    .freq_locked_external_mode(fle),
    .osc_ref_tick(osc_tick),
    .ext_timer_clock_pin(ext_clk),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .cap_in(cap_in),
    .pwm_out(pwm_out),
    .pwm_oe(pwm_oe),
    .irq_ch(irq_ch),
    .irq_ovf(irq_ovf)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [1:0] i, input logic [4:0] o, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= {i, o};
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] i, input logic [4:0] o, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= {i, o};
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // high byte first, low byte comes from the latch
  task automatic rdw(input logic [1:0] i, input logic [4:0] o, output logic [15:0] d);
    rd(i, o, d[15:8]);
    rd(i, o + 5'h01, d[7:0]);
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input logic [15:0] g);
    cmp_count++;
    if ($isunknown(g) || g < lo || g > hi) begin
      n_fail++;
      $display("ERROR %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic pin(input int k, input logic b);
    @(posedge clk_sys);
    cap_in[k] <= b;
    cyc(4);
    #1;
  endtask

  task automatic hi_count(input int k, input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      cnt += (pwm_out[k] === 1'b1);
    end
  endtask

  task automatic toggles(input int k, input int n, output int cnt);
    logic last;
    cnt = 0;
    #1;
    last = pwm_out[k];
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      cnt += (pwm_out[k] !== last);
      last = pwm_out[k];
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(20000);
    n_fail++;
    $display("ERROR watchdog expected done seen timeout");
    results();
  end

  initial begin
    cyc(6);
    resetn <= 1'b1;
    ce <= 1'b1;
    // reset values and channel count per instance
    rd(2'h0, 5'h00, h);
    chk("sc_reset", 16'h0000, h);
    wr(2'h0, 5'h0e, 8'h10);
    rd(2'h0, 5'h0e, h);
    chk("inst0_ch3", 16'h0010, h);
    wr(2'h2, 5'h0e, 8'h10);
    rd(2'h2, 5'h0e, h);
    chk("inst2_ch3", 16'h0000, h);
    wr(2'h3, 5'h00, 8'hff);
    rd(2'h3, 5'h00, h);
    chk("unmapped", 16'h0000, h);
    $display("test reset done");
    // clock sources and prescale taps
    for (int r = 0; r < 6; r++) begin
      cyc(1);
      fle <= t_fle[r];
      ext_en <= (t_sc[r][4:3] == 2'h3);
      wr(2'h1, 5'h01, 8'h00);
      wr(2'h1, 5'h00, t_sc[r]);
      cyc(t_len[r]);
      wr(2'h1, 5'h00, 8'h00);
      rdw(2'h1, 5'h01, w);
      chk_rng("prescale", (t_len[r] + 2) / t_div[r] - 2, (t_len[r] + 2) / t_div[r] + 2, w);
    end
    cyc(1);
    fle <= 1'b0;
    ext_en <= 1'b0;
    wr(2'h1, 5'h02, 8'h55);
    rdw(2'h1, 5'h01, w);
    chk("cnt_clear", 16'h0000, w);
    $display("test prescale done");
    // read latch and debug freeze
    wr(2'h0, 5'h01, 8'h00);
    wr(2'h0, 5'h00, 8'h08);
    rd(2'h0, 5'h02, h);
    cyc(300);
    rd(2'h0, 5'h01, h);
    chk("cnt_hi_latched", 16'h0000, h);
    rd(2'h0, 5'h02, h);
    cyc(600);
    background_debug_state <= 1'b1;
    rd(2'h0, 5'h01, h);
    chk_rng("bdm_cnt_live", 3, 3, h);
    rd(2'h0, 5'h01, h2);
    chk("bdm_cnt_frozen", h, h2);
    wr(2'h0, 5'h00, 8'h08);
    background_debug_state <= 1'b0;
    rd(2'h0, 5'h01, h);
    chk_rng("latch_cleared", 3, 4, h);
    wr(2'h0, 5'h00, 8'h00);
    $display("test latch done");
    // capture edges and write lockout
    wr(2'h1, 5'h00, 8'h08);
    cyc(50);
    wr(2'h1, 5'h00, 8'h00);
    rdw(2'h1, 5'h01, w);
    wr(2'h1, 5'h05, 8'h44);
    wr(2'h1, 5'h06, 8'h12);
    wr(2'h1, 5'h07, 8'h34);
    rdw(2'h1, 5'h06, v);
    chk("cap_wr_ignored", 16'h0000, v);
    for (int e = 1; e < 4; e++) begin
      wr(2'h1, 5'h05, 8'h40 | 8'(e << 2));
      pin(4, 1'b1);
      chk("cap_rise", 16'(e & 1), irq_ch[4]);
      if (e == 1) begin
        rdw(2'h1, 5'h06, v);
        chk("cap_value", w, v);
      end
      wr(2'h1, 5'h05, 8'h40 | 8'(e << 2));
      pin(4, 1'b0);
      chk("cap_fall", 16'(e >> 1), irq_ch[4]);
    end
    $display("test capture done");
    // compare actions and two-byte writes
    wr(2'h2, 5'h04, 8'h13);
    wr(2'h2, 5'h05, 8'h1c);
    wr(2'h2, 5'h06, 8'h00);
    wr(2'h2, 5'h07, 8'h05);
    wr(2'h2, 5'h00, 8'h08);
    cyc(45);
    #1;
    chk("oc_set", 16'h0001, pwm_out[6]);
    chk("oc_oe", 16'h0001, pwm_oe[6]);
    wr(2'h2, 5'h05, 8'h18);
    cyc(45);
    #1;
    chk("oc_clear", 16'h0000, pwm_out[6]);
    wr(2'h2, 5'h05, 8'h14);
    cyc(25);
    toggles(6, 80, c);
    chk("oc_toggle", 16'h0004, 16'(c));
    wr(2'h2, 5'h07, 8'h09);
    cyc(30);
    rdw(2'h2, 5'h06, v);
    chk("half_write", 16'h0005, v);
    $display("test compare done");
    // edge and center PWM, overflow request
    wr(2'h0, 5'h04, 8'h09);
    wr(2'h0, 5'h08, 8'h28);
    wr(2'h0, 5'h09, 8'h00);
    wr(2'h0, 5'h0a, 8'h04);
    wr(2'h0, 5'h00, 8'h48);
    cyc(30);
    #1;
    chk("ovf_irq", 16'h0001, irq_ovf[0]);
    hi_count(1, 100, c);
    chk("pwm_high_true", 16'h0028, 16'(c));
    wr(2'h0, 5'h08, 8'h24);
    cyc(20);
    hi_count(1, 100, c);
    chk("pwm_low_true", 16'h003c, 16'(c));
    wr(2'h0, 5'h08, 8'h28);
    wr(2'h0, 5'h09, 8'h00);
    wr(2'h0, 5'h0a, 8'h09);
    wr(2'h0, 5'h00, 8'h28);
    cyc(60);
    #1;
    chk("ovf_masked", 16'h0000, irq_ovf[0]);
    hi_count(1, 100, c);
    chk("center_aligned_pwm_mode_full", 16'h0064, 16'(c));
    $display("test pwm done");
    results();
  end
endmodule // tb_timer_pwm_capture_compare

`default_nettype wire
